/* inc/game_port_pkg.sv */
package game_port_pkg;

    // Measurement width and saturation value.
    localparam int          CNT_W        = 12;
    localparam logic [11:0] CNT_MAX      = 12'hfff;

    // Counting clock derived from the 10 MHz device clock.
    localparam int          CLK_HZ       = 10000000;
    localparam int          TICK_HZ      = 895000;
    localparam int          TICK_DIV     = CLK_HZ / TICK_HZ;

    // Read sequence positions.
    localparam logic [2:0]  RD_LO_A      = 3'h0;
    localparam logic [2:0]  RD_LO_B      = 3'h1;
    localparam logic [2:0]  RD_LO_C      = 3'h2;
    localparam logic [2:0]  RD_LO_D      = 3'h3;
    localparam logic [2:0]  RD_HI_AB     = 3'h4;
    localparam logic [2:0]  RD_HI_CD     = 3'h5;
    localparam logic [2:0]  RD_SW        = 3'h6;

    // Remote frame joystick fields.
    typedef struct packed {
        logic [3:0]  buttons;
        logic [7:0]  lo_a;
        logic [7:0]  lo_b;
        logic [7:0]  lo_c;
        logic [7:0]  lo_d;
        logic [7:0]  hi_ab;
        logic [7:0]  hi_cd;
    } remote_stick_t;

    // Host port access.
    typedef struct packed {
        logic        wr;
        logic        rd;
    } host_access_t;

endpackage

/* verilog/game_port_timer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Four one-shot outputs, four button inputs.
// - Mode bit selects digital or analog timing.
// - Reads five, six give packed upper nibbles.
// - Read seven gives buttons in bits 3:0.
// - Each measurement is twelve bits, max fff.
// - Counters advance at about 909 kHz while pulsing in digital mode.
// - Docked with substitute bit uses remote values.
// - Dock input high means docked.
// - Remote frame carries buttons, lows, packed nibbles.
module game_port_timer #(
    // Counter width; the saturation value is cut to fit it.
    parameter int CNT_W = game_port_pkg::CNT_W
) (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Host port: trigger write, read strobe and the byte read back.
    input  wire game_port_pkg::host_access_t   host,
    output logic [7:0]                         rd_data,
    // Configuration levels, the dock input and the uploaded remote values.
    input  wire logic                          digital_mode,
    input  wire logic                          remote_sub_en,
    input  wire logic                          docked,
    input  wire game_port_pkg::remote_stick_t  remote,
    // RC feedback and the one-shot pins.
    input  wire logic [3:0]                    pot_pulse,
    output logic                               oneshot_out_a,
    output logic                               oneshot_out_b,
    output logic                               oneshot_out_c,
    output logic                               oneshot_out_d,
    // Joystick buttons.
    input  wire logic                          stick_button_a,
    input  wire logic                          stick_button_b,
    input  wire logic                          stick_button_c,
    input  wire logic                          stick_button_d
);

    ////////////////////////////////////////////////////////////////////////
    // Counting clock enable.

    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       tick;

    // Last count of the divider; the whole-cycle period is the truncated
    // ratio of the device clock to the counting clock.
    localparam logic [7:0] DIV_LAST = 8'(game_port_pkg::TICK_DIV - 1);

    // Divider gives a one-cycle pulse every TICK_DIV clocks. An integer
    // period cannot hit 895 kHz exactly from 10 MHz; eleven clocks give
    // about 909 kHz, so long widths read roughly one and a half per cent
    // high. A fractional accumulator would fix that at the cost of area.
    always_comb begin
        tick     = (div_reg == DIV_LAST);
        div_next = tick ? 8'h00 : div_reg + 8'h01;
    end

    // Registers only; the divider runs freely, so the first tick after a
    // trigger may come anywhere within one period.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One-shots and width counters.
    // One width counter sits behind each one-shot, all clocked by the shared tick.

    // The one-shot fires on the write and ends when the external RC network
    // reports the pulse over; that feedback arrives on pot_pulse.
    logic [3:0]       buttons;
    wire  [3:0]       shot_vec;
    wire  [CNT_W-1:0] cnt_val [4];

    // Buttons are read raw; the host does its own debouncing.
    assign buttons = {stick_button_d, stick_button_c, stick_button_b, stick_button_a};

    // Each channel owns a one-shot and a width counter. Analog mode still
    // fires the one-shots so the host can time them itself; only the counter
    // stays parked at zero.
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        // Channel state stays local so no channel can disturb another.
        logic             fire_reg;
        logic             fire_next;
        logic [CNT_W-1:0] cnt_reg;
        logic [CNT_W-1:0] cnt_next;

        // A write restarts the channel even in mid-pulse, so a stale count
        // never leaks into the next read sequence.
        always_comb begin
            fire_next = fire_reg;
            cnt_next  = cnt_reg;
            if (host.wr) begin
                fire_next = 1'b1;
                cnt_next  = '0;
            end else if (fire_reg) begin
                if (!pot_pulse[ch]) begin
                    // The RC network has timed out, so the pulse ends.
                    fire_next = 1'b0;
                end else if (tick && digital_mode
                             && cnt_reg != CNT_W'(game_port_pkg::CNT_MAX)) begin
                    // Holding at the top value instead of wrapping keeps a very
                    // long pulse reading as the widest one.
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
        end

        // Registers only; every decision sits in the process above.
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                fire_reg <= 1'b0;
                cnt_reg  <= '0;
            end else begin
                fire_reg <= fire_next;
                cnt_reg  <= cnt_next;
            end
        end

        // Hand the channel's state to the pins and to the read logic.
        assign shot_vec[ch] = fire_reg;
        assign cnt_val[ch]  = cnt_reg;
    end

    // The pins come straight from flops, so they cannot glitch while the RC
    // feedback settles near its threshold.
    assign oneshot_out_a = shot_vec[0];
    assign oneshot_out_b = shot_vec[1];
    assign oneshot_out_c = shot_vec[2];
    assign oneshot_out_d = shot_vec[3];

    ////////////////////////////////////////////////////////////////////////
    // Source selection and read sequencing.
    // Both sources share one packed shape, so the read logic never cares which.

    // Source selection state.
    logic                          use_remote;
    game_port_pkg::remote_stick_t  local_view;
    game_port_pkg::remote_stick_t  view;

    // Read pointer and the byte held on the port.
    logic [2:0]                    ptr_reg;
    logic [2:0]                    ptr_next;
    logic [7:0]                    data_reg;
    logic [7:0]                    data_next;

    // Substitution only while docked, so pulling the unit out of the dock
    // falls straight back to the local joystick without any software help.
    // The enable alone does nothing on an undocked unit.
    assign use_remote = docked && remote_sub_en;

    // Local counts packed in the same shape as the remote frame, so a single
    // selection picks a whole source and the two can never be mixed within
    // one slot.
    always_comb begin
        local_view.buttons = buttons;
        local_view.lo_a    = cnt_val[0][7:0];
        local_view.lo_b    = cnt_val[1][7:0];
        local_view.lo_c    = cnt_val[2][7:0];
        local_view.lo_d    = cnt_val[3][7:0];
        local_view.hi_ab   = {cnt_val[1][11:8], cnt_val[0][11:8]};
        local_view.hi_cd   = {cnt_val[3][11:8], cnt_val[2][11:8]};
    end

    // Remote values are taken at read time, not latched at the trigger, so a
    // read always shows the newest upload frame. The trade-off is that a
    // frame landing mid-sequence can mix two frames across the seven reads.
    assign view = use_remote ? remote : local_view;

    // Each read presents the data for the current slot and advances; the
    // pointer parks on the button slot so extra reads stay harmless.
    always_comb begin
        ptr_next  = ptr_reg;
        data_next = data_reg;
        if (host.wr) begin
            // A write in the same cycle as a read wins and rewinds the sequence.
            ptr_next = game_port_pkg::RD_LO_A;
        end else if (host.rd) begin
            // Slots follow the host's fixed read order.
            case (ptr_reg)
                game_port_pkg::RD_LO_A:  data_next = view.lo_a;
                game_port_pkg::RD_LO_B:  data_next = view.lo_b;
                game_port_pkg::RD_LO_C:  data_next = view.lo_c;
                game_port_pkg::RD_LO_D:  data_next = view.lo_d;
                game_port_pkg::RD_HI_AB: data_next = view.hi_ab;
                game_port_pkg::RD_HI_CD: data_next = view.hi_cd;
                game_port_pkg::RD_SW:    data_next = {4'h0, view.buttons};
                default:                 data_next = {4'h0, view.buttons};
            endcase
            // Past the button slot the pointer stays put; measurements are
            // never touched by reads, only by the next trigger.
            if (ptr_reg != game_port_pkg::RD_SW) begin
                ptr_next = ptr_reg + 3'h1;
            end
        end
    end

    // Registers only. Read data comes from a flop so the host sees a value
    // that cannot change while its read cycle is still open.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptr_reg  <= game_port_pkg::RD_LO_A;
            data_reg <= 8'h00;
        end else begin
            ptr_reg  <= ptr_next;
            data_reg <= data_next;
        end
    end

    // The last byte read stays on the port until the next read strobe.
    assign rd_data = data_reg;

endmodule

/* tb/game_port_timer_assertions.sv */
`timescale 1ns/1ps
// Watches the read sequence and the one-shot handshake at the ports.
module game_port_timer_checks (
    input wire logic                         clk,
    input wire logic                         reset,
    input wire game_port_pkg::host_access_t  host,
    input wire logic [7:0]                   rd_data,
    input wire logic                         digital_mode,
    input wire logic                         remote_sub_en,
    input wire logic                         docked,
    input wire game_port_pkg::remote_stick_t remote,
    input wire logic [3:0]                   pot_pulse,
    input wire logic                         oneshot_out_a,
    input wire logic                         oneshot_out_d
);
    logic [2:0]      n_reg;
    logic [2:0]      n_next;
    logic            ana_reg;
    logic [7:0][7:0] seq;
    logic [7:0]      cur;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Reads since the trigger; parks at seven, a slot that repeats the buttons.
    always_comb begin
        n_next = n_reg;
        if (host.wr) n_next = 3'h0;
        else if (host.rd && n_reg != 3'h7) n_next = n_reg + 3'h1;
    end
    // The count starts at the first slot on reset, as the design's pointer does;
    // ana_reg marks counters cleared in analog mode and never counted since.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            n_reg   <= 3'h0;
            ana_reg <= 1'b1;
        end else begin
            n_reg <= n_next;
            if (host.wr) ana_reg <= !digital_mode;
            else if (digital_mode) ana_reg <= 1'b0;
        end
    end
    // Expected substituted byte for each read position.
    assign seq = {{2{4'h0, remote.buttons}}, remote.hi_cd, remote.hi_ab,
                  remote.lo_d, remote.lo_c, remote.lo_b, remote.lo_a};
    assign cur = seq[n_reg];
    a_wr_fires: assert property (host.wr |=> oneshot_out_a && oneshot_out_d)
        else $error("one-shot missing after trigger");
    a_shot_drops: assert property (oneshot_out_a && !pot_pulse[0] && !host.wr |=> !oneshot_out_a)
        else $error("one-shot outlived its pulse");
    a_shot_holds: assert property (oneshot_out_d && pot_pulse[3] |=> oneshot_out_d)
        else $error("one-shot ended early");
    a_shot_origin: assert property ($rose(oneshot_out_a) |-> $past(host.wr))
        else $error("one-shot fired without trigger");
    a_fall_cause: assert property ($fell(oneshot_out_d) |-> !$past(pot_pulse[3]))
        else $error("one-shot fell while pulse high");
    a_rd_holds: assert property (!host.rd && !host.wr |=> $stable(rd_data))
        else $error("read data moved without a read");
    a_remote_read: assert property (docked && remote_sub_en && digital_mode && host.rd
        && !host.wr |=> rd_data == $past(cur))
        else $error("substituted byte wrong");
    a_analog_zero: assert property (!digital_mode && !docked && host.rd && !host.wr
        && n_reg < 3'h6 && ana_reg |=> rd_data == 8'h00)
        else $error("analog mode measured");
endmodule
bind game_port_timer game_port_timer_checks u_chk (.clk(clk), .reset(reset), .host(host),
    .rd_data(rd_data), .digital_mode(digital_mode), .remote_sub_en(remote_sub_en),
    .docked(docked), .remote(remote), .pot_pulse(pot_pulse),
    .oneshot_out_a(oneshot_out_a), .oneshot_out_d(oneshot_out_d));

/* tb/pot_legs.sv */
`timescale 1ns/1ps
// Four RC legs: each stays high for len clocks once its one-shot fires.
module pot_legs (
    input wire logic             clk,
    input wire logic             reset,
    input wire logic [3:0]       fire,
    input wire logic [3:0][15:0] len,
    output logic [3:0]           pot_pulse
);
    logic [3:0][15:0] age_reg;
    // Age restarts whenever a leg is idle, so a new trigger times afresh.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            age_reg <= '0;
        end else begin
            for (int i = 0; i < 4; i++) age_reg[i] <= fire[i] ? age_reg[i] + 16'h1 : 16'h0;
        end
    end
    // A leg with zero length never rises, which models a shorted pot.
    always_comb begin
        for (int i = 0; i < 4; i++) pot_pulse[i] = fire[i] && age_reg[i] < len[i];
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, reset = 1'b1, dm = 1'b1, sub = 1'b0, dk = 1'b0;
    game_port_pkg::host_access_t host = '0;
    game_port_pkg::remote_stick_t rem = {4'h9, 48'h11223344c35a};
    logic [7:0] v;
    wire  [7:0] rd_data;
    wire  [3:0] pp, shot;
    logic [3:0] btn = 4'ha;
    logic [3:0][15:0] len = '0;
    int fails = 0, cmp_count = 0, k;
    localparam logic [7:0] ROWS [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hc3, 8'h5a, 8'h09, 8'h09};
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
    initial forever #50 clk = ~clk;
    game_port_timer u_dut (.clk(clk), .reset(reset), .host(host), .rd_data(rd_data),
        .digital_mode(dm), .remote_sub_en(sub), .docked(dk), .remote(rem), .pot_pulse(pp),
        .oneshot_out_a(shot[0]), .oneshot_out_b(shot[1]), .oneshot_out_c(shot[2]),
        .oneshot_out_d(shot[3]), .stick_button_a(btn[0]), .stick_button_b(btn[1]),
        .stick_button_c(btn[2]), .stick_button_d(btn[3]));
    pot_legs u_legs (.clk(clk), .reset(reset), .fire(shot), .len(len), .pot_pulse(pp));
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Trigger, then poll between edges, clear of the flop updates, until every
    // one-shot has dropped under a bound; return on a rising edge.
    task trig;
        host.wr <= 1'b1;
        @(posedge clk) host.wr <= 1'b0;
        @(negedge clk);
        for (k = 0; k < 60000 && shot !== 4'h0; k++) @(negedge clk);
        if (k == 60000) begin
            fails++;
            $display("unexpected at %0t: one-shot never ended", $time);
            end_sim;
        end
        @(posedge clk);
    endtask
    // Data is taken at the falling edge, clear of the register update.
    task rd;
        host.rd <= 1'b1;
        @(posedge clk) host.rd <= 1'b0;
        @(negedge clk) v = rd_data;
        @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk) `CHK({rd_data, shot}, 12'h000)
        dk <= 1'b1;
        sub <= 1'b1;
        trig;
        for (int i = 0; i < 8; i++) begin rd; `CHK(v, ROWS[i]) end
        $display("remote rows done");
        dk <= 1'b0;
        len <= {16'hc350, 16'h00dc, 16'h0037, 16'h0000};
        trig;
        rd; `CHK(v, 8'h00)
        rd; `CHK(v inside {[8'h04:8'h06]}, 1'b1)
        rd; `CHK(v inside {[8'h13:8'h15]}, 1'b1)
        rd; `CHK(v, 8'hff)
        rd; `CHK(v, 8'h00)
        rd; `CHK(v, 8'hf0)
        btn <= 4'h5;
        rd; `CHK(v, 8'h05)
        rd; `CHK(v, 8'h05)
        $display("local measure done");
        dm <= 1'b0;
        len <= {4{16'h0037}};
        trig;
        rd; `CHK(v, 8'h00)
        host.wr <= 1'b1;
        @(posedge clk) host.wr <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({rd_data, shot}, 12'h000)
        $display("analog and reset done");
        end_sim;
    end
endmodule
